// ==== far_end.sv ====
`timescale 1ns/1ps
// remote serial terminal: drives the device receive line, decodes the device transmit line
module far_end #(
	parameter int BIT_CLKS = 16
) (
	input  wire logic       clk_i,
	input  wire logic       line_i,
	input  wire logic [1:0] wl_i,
	input  wire logic       par_en_i,
	output logic            line_o,
	output logic [7:0]      got_o,
	output logic            got_par_o,
	output int              cnt_o,
	output int              len_o
);
	int cyc      = 0;
	int start_at = 0;

	// line idles high until a frame is sent
	initial begin
		line_o    = 1'b1;
		got_o     = 8'h00;
		got_par_o = 1'b0;
		cnt_o     = 0;
		len_o     = 0;
	end

	// one frame: low start, data lsb first, optional parity, high stop time
	task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic pb, input int stop_clks);
		line_o <= 1'b0;
		repeat (BIT_CLKS) @(posedge clk_i);
		for (int i = 0; i < nb; i++) begin
			line_o <= d[i];
			repeat (BIT_CLKS) @(posedge clk_i);
		end
		if (pe) begin
			line_o <= pb;
			repeat (BIT_CLKS) @(posedge clk_i);
		end
		line_o <= 1'b1;
		repeat (stop_clks) @(posedge clk_i);
	endtask

	// break: hold the line low, then release to idle
	task automatic hold_low(input int clks);
		line_o <= 1'b0;
		repeat (clks) @(posedge clk_i);
		line_o <= 1'b1;
		repeat (BIT_CLKS * 2) @(posedge clk_i);
	endtask

	// free cycle count, used to time start edge to start edge
	always @(posedge clk_i) cyc <= cyc + 1;

	// decoder samples mid-bit; a frame counts only with a high stop bit
	always begin
		@(negedge line_i);
		len_o    = cyc - start_at;
		start_at = cyc;
		got_o    = 8'h00;
		repeat (BIT_CLKS / 2) @(posedge clk_i);
		for (int i = 0; i < 5 + int'(wl_i); i++) begin
			repeat (BIT_CLKS) @(posedge clk_i);
			got_o[i] = line_i;
		end
		if (par_en_i) begin
			repeat (BIT_CLKS) @(posedge clk_i);
			got_par_o = line_i;
		end
		repeat (BIT_CLKS) @(posedge clk_i);
		if (line_i === 1'b1)
			cnt_o = cnt_o + 1;
	end
endmodule

// ==== rx_char_if.sv ====
`timescale 1ns/1ps
interface rx_char_if;
	logic       tick;
	logic       line;
	logic       enable;
	logic [1:0] wl;
	logic       par_en;
	logic       even;
	logic       force_en;
	logic       valid;
	logic [7:0] data;
	logic       perr;
	logic       ferr;
	logic       brk;
	modport engine (input tick, line, enable, wl, par_en, even, force_en, output valid, data, perr, ferr, brk);
	modport core (output tick, line, enable, wl, par_en, even, force_en, input valid, data, perr, ferr, brk);
endinterface

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "uart_lmc_regs.svh"
module tb_top;
	logic        clk_i    = 1'b0;
	logic        rst_i    = 1'b1;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic        wb_we_i  = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic [3:0]  mdm_n    = 4'hf;
	logic [1:0]  wl_cfg   = 2'h0;
	logic        par_cfg  = 1'b0;
	logic        ir_strap = 1'b0;
	logic [31:0] seed     = 32'hc9984835;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, tx_o, rx_line, rts_n_o, dtr_n_o, irq;
	int          fails    = 0;
	int          compares = 0;

	always #20 clk_i = ~clk_i;

	uart_line_modem_control_status u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(4'h1), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .rx_i(rx_line), .tx_o(tx_o), .ir_strap_i(ir_strap), .cts_n_i(mdm_n[0]),
		.dsr_n_i(mdm_n[1]), .ri_n_i(mdm_n[2]), .cd_n_i(mdm_n[3]), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o),
		.line_status_irq_o(irq));
	far_end u_far (.clk_i(clk_i), .line_i(tx_o), .wl_i(wl_cfg), .par_en_i(par_cfg), .line_o(rx_line),
		.got_o(), .got_par_o(), .cnt_o(), .len_o());

	// xorshift source and expectation helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] wmask(input logic [7:0] lfc);
		return 8'hff >> (2'h3 - lfc[1:0]);
	endfunction
	function automatic logic exp_par(input logic [7:0] d, input logic [7:0] lfc);
		if (lfc[`LFC_FORCE])
			return ~lfc[`LFC_EVEN];
		return lfc[`LFC_EVEN] ? ^(d & wmask(lfc)) : ~^(d & wmask(lfc));
	endfunction
	function automatic int stop_clks(input logic [7:0] lfc);
		if (!lfc[`LFC_STOP])
			return 16;
		return (lfc[1:0] == 2'h0) ? 24 : 32;
	endfunction

	task automatic stop_test();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// classic wishbone cycle: hold everything until ack is sampled high
	task automatic wb(input logic [7:0] a, input logic we, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge clk_i);
		wb_adr_i <= a;
		wb_we_i  <= we;
		wb_dat_i <= {24'h0, d};
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) begin
			fails++;
			stop_test();
		end
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(a, 1'b1, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] q;
		wb(a, 1'b0, 8'h00, q);
		chk(q & m, e);
	endtask
	task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] q;
		int n;
		n = 0;
		do begin
			wb(a, 1'b0, 8'h00, q);
			n++;
		end while ((q & m) !== e && n < 300);
		chk(q & m, e);
		if ((q & m) !== e)
			stop_test();
	endtask
	task automatic wait_tx(input int target);
		int n;
		n = 0;
		while (u_far.cnt_o < target && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		if (u_far.cnt_o < target) begin
			fails++;
			stop_test();
		end
	endtask

	// hang guard
	initial begin
		repeat (100000) @(posedge clk_i);
		fails++;
		stop_test();
	end

	// main sequence
	initial begin
		logic [7:0] modes [5];
		logic [7:0] lfc, d, d2;
		logic [31:0] r;
		int c, fl;
		modes = '{8'h00, 8'h08, 8'h18, 8'h28, 8'h38};
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values, pins, unmapped place, guarded upper control bits
		rd_chk(`OFS_LFC, 8'hff, `LFC_RST);
		rd_chk(`OFS_MLC, 8'hff, `MLC_RST);
		rd_chk(`OFS_LSF, 8'hff, 8'h60);
		chk({6'h0, rts_n_o, dtr_n_o}, 8'h03);
		rd_chk(8'h40, 8'hff, 8'h00);
		wr(`OFS_MLC, 8'he3);
		rd_chk(`OFS_MLC, 8'hff, 8'h03);
		chk({6'h0, rts_n_o, dtr_n_o}, 8'h00);
		wr(`OFS_MLC, 8'h00);
		// transmit every word length and parity mode, two bytes back to back
		for (int i = 0; i < 20; i++) begin
			r = rnd();
			lfc = modes[i % 5] | 8'(i / 5) | {5'h0, r[8], 2'h0};
			d = r[7:0];
			d2 = r[23:16];
			wl_cfg <= lfc[1:0];
			par_cfg <= lfc[3];
			fl = 16 * (6 + int'(lfc[1:0]) + int'(lfc[3])) + stop_clks(lfc);
			wr(`OFS_LFC, lfc);
			c = u_far.cnt_o;
			wr(`OFS_DATA, d);
			rd_chk(`OFS_LSF, 8'h40, 8'h00);
			poll(`OFS_LSF, 8'h20, 8'h20);
			wr(`OFS_DATA, d2);
			wait_tx(c + 1);
			chk(u_far.got_o, d & wmask(lfc));
			if (lfc[3])
				chk({7'h0, u_far.got_par_o}, {7'h0, exp_par(d, lfc)});
			wait_tx(c + 2);
			chk(u_far.got_o, d2 & wmask(lfc));
			chk({7'h0, (u_far.len_o - fl) inside {0, 1}}, 8'h01);
			poll(`OFS_LSF, 8'h60, 8'h60);
		end
		// immediate send clears its own request
		wr(`OFS_LFC, 8'h03);
		wl_cfg <= 2'h3;
		par_cfg <= 1'b0;
		c = u_far.cnt_o;
		wr(`OFS_MLC, 8'h08);
		wr(`OFS_DATA, 8'ha5);
		rd_chk(`OFS_MLC, 8'h08, 8'h00);
		wait_tx(c + 1);
		chk(u_far.got_o, 8'ha5);
		// receive random formats with good parity
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			lfc = {2'h0, r[13:8]} & 8'h3f;
			d = r[7:0];
			wr(`OFS_LFC, lfc);
			u_far.send(d, 5 + int'(lfc[1:0]), lfc[3], exp_par(d, lfc), stop_clks(lfc));
			repeat (4) @(posedge clk_i);
			rd_chk(`OFS_LSF, 8'h9f, 8'h01);
			rd_chk(`OFS_DATA, wmask(lfc), d & wmask(lfc));
			rd_chk(`OFS_LSF, 8'h01, 8'h00);
		end
		// parity error raises the line status interrupt
		wr(`OFS_IER, 8'h04);
		wr(`OFS_LFC, 8'h1b);
		u_far.send(8'h3c, 8, 1'b1, ~exp_par(8'h3c, 8'h1b), 16);
		repeat (4) @(posedge clk_i);
		rd_chk(`OFS_LSF, 8'h9f, 8'h85);
		chk({7'h0, irq}, 8'h01);
		rd_chk(`OFS_DATA, 8'hff, 8'h3c);
		rd_chk(`OFS_LSF, 8'h84, 8'h00);
		chk({7'h0, irq}, 8'h00);
		// overrun keeps the held character
		u_far.send(8'h5a, 8, 1'b1, exp_par(8'h5a, 8'h1b), 16);
		u_far.send(8'hc3, 8, 1'b1, exp_par(8'hc3, 8'h1b), 16);
		repeat (4) @(posedge clk_i);
		rd_chk(`OFS_LSF, 8'h03, 8'h03);
		rd_chk(`OFS_DATA, 8'hff, 8'h5a);
		// long break loads a single break character
		u_far.hold_low(16 * 36);
		rd_chk(`OFS_LSF, 8'h9f, 8'h99);
		rd_chk(`OFS_DATA, 8'hff, 8'h00);
		// loopback drives carrier and ring status
		wr(`OFS_MLC, 8'h18);
		rd_chk(`OFS_MIS, 8'h80, 8'h80);
		wr(`OFS_MLC, 8'h14);
		rd_chk(`OFS_MIS, 8'hc0, 8'h40);
		wr(`OFS_MLC, 8'h00);
		rd_chk(`OFS_MIS, 8'hf0, 8'h00);
		// each modem input change sets its own delta flag
		for (int k = 0; k < 4; k++) begin
			mdm_n[k] <= ~mdm_n[k];
			repeat (4) @(posedge clk_i);
			rd_chk(`OFS_MIS, 8'h0f, 8'h01 << k);
		end
		// enhanced enable opens the upper control bits, then reset reloads the strap
		wr(`OFS_EFR, 8'h10);
		wr(`OFS_MLC, 8'he3);
		rd_chk(`OFS_MLC, 8'hff, 8'he3);
		ir_strap <= 1'b1;
		rst_i    <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i    <= 1'b0;
		rd_chk(`OFS_MLC, 8'hff, 8'h40);
		stop_test();
	end
endmodule

// ==== uart_line_modem_control_status.sv ====
// Function
// [R1] parity enable adds and checks parity bit
// [R2] stop select: 1, 1.5 or 2 stops
// [R3] word length code selects 5 to 8
// [R4] prescaler divides baud input by four
// [R5] infrared bit from strap, encoded line
// [R6] any received character resumes halted transmit
// [R7] immediate byte jumps ahead of queued bytes
// [R8] immediate send self clears, needs transmitter enabled
// [R9] pending flow characters precede immediate byte
// [R10] host writes custom byte right after arming
// [R11] loopback maps outputs onto carrier, ring status
// [R12] pair select picks handshake pin pair
// [R13] control bits drive active-low pins inverted
// [R14] line status interrupt on any error
// [R15] error summary while errors held in fifo
// [R16] transmitter empty when fifo and shifter idle
// [R17] transmit fifo empty flag tracks loads
// [R18] full-frame low gives one break character
// [R19] framing and parity flags describe top entry
// [R20] overrun flags, keeps fifo contents intact
// [R21] data ready while receive fifo holds data
// [R22] low modem status bits flag changes
// [R23] even select and forced mark or space
// [R24] start, data lsb first, parity, stops
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "uart_lmc_regs.svh"
module uart_line_modem_control_status #(
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        rx_i,
	output logic             tx_o,
	input  wire logic        ir_strap_i,
	input  wire logic        cts_n_i,
	input  wire logic        dsr_n_i,
	input  wire logic        cd_n_i,
	input  wire logic        ri_n_i,
	output logic             rts_n_o,
	output logic             dtr_n_o,
	output logic             line_status_irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	logic        ack_r;
	logic [31:0] dat_r;
	logic [7:0]  ier_r, lfc_r, mlc_r, efr_r, misw_r;
	logic        fifo_en_r, strap_pend_r;
	logic [15:0] div_r, bcnt_r;
	logic [1:0]  pre_r;
	logic [3:0]  msts_q_r, delta_r;
	logic [4:0]  ird_r;
	logic [7:0]  txm [DEPTH];
	logic [10:0] rxm [DEPTH];
	logic [AW-1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
	logic [AW:0] tx_cnt_r, rx_cnt_r, err_cnt_r;
	logic        ovr_r, sw_halt_r, pend_xoff_r, pend_xon_r, xoff_sent_r;
	logic        imm_r;
	logic [7:0]  imm_d_r;
	uart_lmc_pkg::frame_state_t tx_st_r;
	logic [4:0]  tx_tc_r;
	logic [2:0]  tx_bit_r;
	logic [7:0]  tx_sh_r;
	logic        tx_par_r, txo_r;

	rx_char_if rxc ();

	uart_rx_engine u_rx (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.rx    (rxc)
	);

	// bus strobes, one access per request
	wire acc      = wb_cyc_i && wb_stb_i && !ack_r;
	wire wr       = acc && wb_we_i && wb_sel_i[0];
	wire rd       = acc && !wb_we_i;
	wire [7:0] wd = wb_dat_i[7:0];
	wire wr_data  = wr && hit(wb_adr_i, `OFS_DATA);
	wire wr_mlc   = wr && hit(wb_adr_i, `OFS_MLC);
	wire wr_fifo  = wr && hit(wb_adr_i, `OFS_FIFO);
	wire rd_data  = rd && hit(wb_adr_i, `OFS_DATA);
	wire rd_lsf   = rd && hit(wb_adr_i, `OFS_LSF);
	wire rd_mis   = rd && hit(wb_adr_i, `OFS_MIS);
	wire enh      = efr_r[`EFR_ENH];
	wire loop     = mlc_r[`MLC_LOOP];
	wire ir_en    = mlc_r[`MLC_IR];
	wire sw_en    = efr_r[`EFR_SWFLOW];
	wire tx_dis   = misw_r[`MIS_TXDIS];

	// baud tick: optional divide by four then divisor
	wire pre_en = !mlc_r[`MLC_PRESC] || pre_r == 2'h3; // R4
	wire tick   = pre_en && bcnt_r == div_r - 16'h0001;

	// modem status, loopback feeds outputs back
	wire [3:0] msts = loop ? {mlc_r[`MLC_IMM], mlc_r[`MLC_PAIR], mlc_r[`MLC_DTR], mlc_r[`MLC_RTS]} // R11
		: {~cd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i};

	// fifo fill levels and limits
	wire [AW:0] cap   = fifo_en_r ? (AW+1)'(DEPTH) : (AW+1)'(1);
	wire tx_full      = tx_cnt_r >= cap;
	wire rx_full      = rx_cnt_r >= cap;
	wire rx_hi        = fifo_en_r && rx_cnt_r >= (AW+1)'(DEPTH / 2);
	wire tx_clr       = wr_fifo && wd[0] && wd[2];
	wire rx_clr       = wr_fifo && wd[0] && wd[1];
	wire [10:0] top   = rxm[rx_rp_r];
	wire rx_any       = rx_cnt_r != '0;
	wire rx_push      = rxc.valid && !rx_full;
	wire rx_pop       = rd_data && rx_any;
	wire ovr_set      = rxc.valid && rx_full; // R20
	wire push_err     = rx_push && (rxc.perr || rxc.ferr || rxc.brk);
	wire pop_err      = rx_pop && top[10:8] != 3'h0;

	// immediate byte capture on the data write after arming
	wire imm_take = wr_data && mlc_r[`MLC_IMM] && !loop && !tx_dis; // R8
	wire tx_push  = wr_data && !imm_take && !tx_full;

	// handshake blocking of the transmitter
	wire hw_block = efr_r[`EFR_AUTO_IN] && !(mlc_r[`MLC_PAIR] ? msts[1] : msts[0]); // R12
	wire tx_idle  = tx_st_r == uart_lmc_pkg::ST_IDLE;
	wire start_ok = tick && tx_idle && !tx_dis;
	wire go_flow  = start_ok && sw_en && (pend_xoff_r || pend_xon_r); // R9
	wire go_imm   = start_ok && !go_flow && imm_r; // R7
	wire go_fifo  = start_ok && !go_flow && !imm_r && tx_cnt_r != '0 && !sw_halt_r && !hw_block;
	wire [7:0] pick = go_flow ? (pend_xoff_r ? `XOFF_CHAR : `XON_CHAR) : imm_r ? imm_d_r : txm[tx_rp_r];

	// transmit bit timing, stop length by word length
	wire [1:0] wl     = lfc_r[1:0];
	wire [2:0] tx_last = 3'h4 + {1'b0, wl}; // R3
	wire [4:0] stop_last = !lfc_r[`LFC_STOP] ? `BIT_LAST : wl == 2'h0 ? `STOP15_LAST : `STOP2_LAST; // R2
	wire [4:0] tc_end = tx_st_r == uart_lmc_pkg::ST_STOP ? stop_last : `BIT_LAST;
	wire tc_done      = tick && tx_tc_r == tc_end;
	wire tx_line      = lfc_r[`LFC_BREAK] ? 1'b0
		: tx_st_r == uart_lmc_pkg::ST_START ? 1'b0
		: tx_st_r == uart_lmc_pkg::ST_DATA ? tx_sh_r[0]
		: tx_st_r == uart_lmc_pkg::ST_PAR ? tx_par_r : 1'b1; // R24
	wire ir_pulse     = !tx_line && tx_tc_r >= `IR_PULSE_LO && tx_tc_r <= `IR_PULSE_HI; // R5
	wire tx_pin       = loop ? 1'b1 : ir_en ? ir_pulse : tx_line;

	// status words
	wire thre = tx_cnt_r == '0; // R17
	wire temt = thre && !imm_r && tx_idle; // R16
	wire [7:0] lsf = {err_cnt_r != '0, temt, thre, rx_any && top[10], rx_any && top[9], // R15 R19
		rx_any && top[8], ovr_r, rx_any}; // R21
	wire [7:0] rdata = hit(wb_adr_i, `OFS_DATA) ? top[7:0]
		: hit(wb_adr_i, `OFS_IER) ? ier_r
		: hit(wb_adr_i, `OFS_LFC) ? lfc_r
		: hit(wb_adr_i, `OFS_MLC) ? mlc_r
		: hit(wb_adr_i, `OFS_LSF) ? lsf
		: hit(wb_adr_i, `OFS_MIS) ? {msts, delta_r}
		: hit(wb_adr_i, `OFS_EFR) ? efr_r
		: hit(wb_adr_i, `OFS_FIFO) ? {7'h00, fifo_en_r}
		: hit(wb_adr_i, `OFS_DIV) ? div_r[7:0] : 8'h00;

	// receive engine hookup, loopback and infrared paths
	assign rxc.tick     = tick;
	assign rxc.line     = loop ? tx_line : ir_en ? ird_r == 5'h00 : rx_i; // R5 R11
	assign rxc.enable   = !misw_r[`MIS_RXDIS];
	assign rxc.wl       = wl;
	assign rxc.par_en   = lfc_r[`LFC_PAR_EN];
	assign rxc.even     = lfc_r[`LFC_EVEN];
	assign rxc.force_en = lfc_r[`LFC_FORCE];

	// pins and bus answer
	assign rts_n_o = !(mlc_r[`MLC_RTS] && !loop && !(efr_r[`EFR_AUTO_OUT] && !mlc_r[`MLC_PAIR] && rx_hi)); // R13
	assign dtr_n_o = !(mlc_r[`MLC_DTR] && !loop && !(efr_r[`EFR_AUTO_OUT] && mlc_r[`MLC_PAIR] && rx_hi)); // R13
	assign line_status_irq_o = ier_r[`IER_LSI] && (err_cnt_r != '0 || ovr_r); // R14
	assign tx_o     = txo_r;
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// bus slave and control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
			ier_r <= 8'h00;
			lfc_r <= `LFC_RST;
			efr_r <= 8'h00;
			misw_r <= 8'h00;
			fifo_en_r <= 1'b0;
			div_r <= `DIV_RST;
		end else begin
			ack_r <= acc;
			if (rd)
				dat_r <= {24'h00_0000, rdata};
			if (wr && hit(wb_adr_i, `OFS_IER))
				ier_r <= wd;
			if (wr && hit(wb_adr_i, `OFS_LFC))
				lfc_r <= wd;
			if (wr && hit(wb_adr_i, `OFS_EFR))
				efr_r <= wd;
			if (wr && hit(wb_adr_i, `OFS_MIS))
				misw_r <= wd & 8'h0c;
			if (wr_fifo)
				fifo_en_r <= wd[0];
			if (wr && hit(wb_adr_i, `OFS_DIV))
				div_r <= {8'h00, wd};
		end
	end

	// modem control, enhanced bits gated, strap caught after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mlc_r <= `MLC_RST;
			strap_pend_r <= 1'b1;
		end else begin
			strap_pend_r <= 1'b0;
			if (wr_mlc)
				mlc_r <= enh ? wd : {mlc_r[7:5], wd[4:0]}; // R4 R6
			else if (imm_take)
				mlc_r[`MLC_IMM] <= 1'b0; // R8
			if (strap_pend_r)
				mlc_r[`MLC_IR] <= ir_strap_i; // R5
		end
	end

	// baud divider, modem deltas, infrared decode stretch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_r <= 2'h0;
			bcnt_r <= 16'h0000;
			msts_q_r <= 4'h0;
			delta_r <= 4'h0;
			ird_r <= 5'h00;
		end else begin
			pre_r <= pre_r + 2'h1;
			if (pre_en)
				bcnt_r <= tick ? 16'h0000 : bcnt_r + 16'h0001;
			msts_q_r <= msts;
			delta_r <= (delta_r & {4{!rd_mis}}) | (msts ^ msts_q_r); // R22
			if (rx_i)
				ird_r <= `IR_HOLD;
			else if (tick && ird_r != 5'h00)
				ird_r <= ird_r - 5'h01;
		end
	end

	// fifo storage
	always_ff @(posedge clk_i) begin
		if (tx_push)
			txm[tx_wp_r] <= wd;
		if (rx_push)
			rxm[rx_wp_r] <= {rxc.brk, rxc.ferr, rxc.perr, rxc.data};
	end

	// fifo pointers, levels, error count and overrun
	always_ff @(posedge clk_i) begin
		if (rst_i || tx_clr) begin
			tx_wp_r <= '0;
			tx_rp_r <= '0;
			tx_cnt_r <= '0;
		end else begin
			tx_wp_r <= tx_wp_r + AW'(tx_push);
			tx_rp_r <= tx_rp_r + AW'(go_fifo);
			tx_cnt_r <= tx_cnt_r + (AW+1)'(tx_push) - (AW+1)'(go_fifo); // R17
		end
		if (rst_i || rx_clr) begin
			rx_wp_r <= '0;
			rx_rp_r <= '0;
			rx_cnt_r <= '0;
			err_cnt_r <= '0;
		end else begin
			rx_wp_r <= rx_wp_r + AW'(rx_push);
			rx_rp_r <= rx_rp_r + AW'(rx_pop);
			rx_cnt_r <= rx_cnt_r + (AW+1)'(rx_push) - (AW+1)'(rx_pop); // R21
			err_cnt_r <= err_cnt_r + (AW+1)'(push_err) - (AW+1)'(pop_err); // R15
		end
		if (rst_i)
			ovr_r <= 1'b0;
		else
			ovr_r <= ovr_set || (ovr_r && !rd_lsf); // R20
	end

	// software flow: halt, resume and pending flow characters
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_halt_r <= 1'b0;
			pend_xoff_r <= 1'b0;
			pend_xon_r <= 1'b0;
			xoff_sent_r <= 1'b0;
		end else begin
			if (rxc.valid && sw_en && rxc.data == `XOFF_CHAR)
				sw_halt_r <= 1'b1;
			else if (rxc.valid && (rxc.data == `XON_CHAR || mlc_r[`MLC_XANY])) // R6
				sw_halt_r <= 1'b0;
			if (go_flow && pend_xoff_r) begin
				pend_xoff_r <= 1'b0;
				xoff_sent_r <= 1'b1;
			end else if (sw_en && rx_hi && !xoff_sent_r)
				pend_xoff_r <= 1'b1;
			if (go_flow && !pend_xoff_r) begin
				pend_xon_r <= 1'b0;
				xoff_sent_r <= 1'b0;
			end else if (xoff_sent_r && !rx_any)
				pend_xon_r <= 1'b1;
		end
	end

	// immediate byte holder, new capture wins over its use
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			imm_r <= 1'b0;
			imm_d_r <= 8'h00;
		end else begin
			imm_r <= imm_take || (imm_r && !go_imm); // R7
			if (imm_take)
				imm_d_r <= wd;
		end
	end

	// transmit frame walker
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_st_r <= uart_lmc_pkg::ST_IDLE;
			tx_tc_r <= 5'h00;
			tx_bit_r <= 3'h0;
			tx_sh_r <= 8'h00;
			tx_par_r <= 1'b0;
			txo_r <= 1'b1;
		end else begin
			txo_r <= tx_pin;
			if (tick && !tx_idle)
				tx_tc_r <= tc_done ? 5'h00 : tx_tc_r + 5'h01;
			case (tx_st_r)
				uart_lmc_pkg::ST_IDLE: begin
					tx_tc_r <= 5'h00;
					if (go_flow || go_imm || go_fifo) begin
						tx_sh_r <= pick;
						tx_par_r <= uart_lmc_pkg::parity_bit(pick, wl, lfc_r[`LFC_EVEN], lfc_r[`LFC_FORCE]); // R23
						tx_st_r <= uart_lmc_pkg::ST_START;
					end
				end
				uart_lmc_pkg::ST_START: begin
					tx_bit_r <= 3'h0;
					if (tc_done)
						tx_st_r <= uart_lmc_pkg::ST_DATA; // R24
				end
				uart_lmc_pkg::ST_DATA: begin
					if (tc_done) begin
						tx_sh_r <= {1'b0, tx_sh_r[7:1]};
						tx_bit_r <= tx_bit_r + 3'h1;
						if (tx_bit_r == tx_last)
							tx_st_r <= lfc_r[`LFC_PAR_EN] ? uart_lmc_pkg::ST_PAR : uart_lmc_pkg::ST_STOP; // R1
					end
				end
				uart_lmc_pkg::ST_PAR: begin
					if (tc_done)
						tx_st_r <= uart_lmc_pkg::ST_STOP;
				end
				uart_lmc_pkg::ST_STOP: begin
					if (tc_done) // R2
						tx_st_r <= uart_lmc_pkg::ST_IDLE;
				end
				default: tx_st_r <= uart_lmc_pkg::ST_IDLE;
			endcase
		end
	end

	// checks
	a_bus_ack: assert property (acc |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle after request");
	a_temt_idle: assert property (temt && !ir_en && !lfc_r[`LFC_BREAK] |=> tx_o) else $error("temt while busy"); // R16
	a_thre_load: assert property (tx_push && !go_fifo |=> !lsf[5]) else $error("thre after load"); // R17
	a_imm_clear: assert property (imm_take |=> !mlc_r[`MLC_IMM] && imm_r) else $error("imm not cleared"); // R8
	a_imm_first: assert property (go_imm |=> tx_sh_r == $past(imm_d_r)) else $error("wrong byte loaded"); // R7
	a_ovr_keep: assert property (ovr_set && !rx_pop && !rx_clr |=> ovr_r && $stable(rx_cnt_r)) else $error("overrun"); // R20
	a_err_sum: assert property (push_err && !pop_err && !rx_clr |=> lsf[7]) else $error("error summary missing"); // R15
	a_lsi_irq: assert property (ier_r[`IER_LSI] && lsf[7] |-> line_status_irq_o) else $error("no line irq"); // R14
	a_loop_cd: assert property (loop && mlc_r[`MLC_IMM] && rd_mis |=> wb_dat_o[7]) else $error("loopback cd"); // R11
	a_ir_idle: assert property (ir_en && !loop && tx_idle && !lfc_r[`LFC_BREAK] |=> !tx_o) else $error("ir idle"); // R5
	a_stop_end: assert property (tx_st_r == uart_lmc_pkg::ST_STOP && tc_done |=> tx_idle) else $error("stop"); // R2
	a_rts_pin: assert property (!mlc_r[`MLC_RTS] |-> rts_n_o) else $error("rts pin not high"); // R13
	c_imm_send: cover property (imm_take ##[1:600] go_imm);
	c_overrun: cover property (ovr_set);
	c_break: cover property (rxc.valid && rxc.brk);
	c_loop_rx: cover property (loop && rx_push);
endmodule

// ==== uart_lmc_pkg.sv ====
package uart_lmc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_START = 3'h1,
		ST_DATA  = 3'h3,
		ST_PAR   = 3'h2,
		ST_STOP  = 3'h6,
		ST_BRK   = 3'h7
	} frame_state_t;

	// parity bit over the active word, shared by both directions
	function automatic logic parity_bit(input logic [7:0] d, input logic [1:0] wl, input logic even,
		input logic force_en);
		logic [7:0] m;
		m = 8'h1f;
		case (wl)
			2'h1: m = 8'h3f;
			2'h2: m = 8'h7f;
			2'h3: m = 8'hff;
			default: m = 8'h1f;
		endcase
		if (force_en)
			parity_bit = ~even;
		else
			parity_bit = even ? ^(d & m) : ~^(d & m);
	endfunction
endpackage

// ==== uart_lmc_regs.svh ====
`ifndef UART_LMC_REGS_SVH
`define UART_LMC_REGS_SVH
// register byte offsets on the wishbone bus
`define OFS_DATA     8'h00
`define OFS_IER      8'h04
`define OFS_LFC      8'h08
`define OFS_MLC      8'h0c
`define OFS_LSF      8'h10
`define OFS_MIS      8'h14
`define OFS_EFR      8'h18
`define OFS_FIFO     8'h1c
`define OFS_DIV      8'h20
// line_format_control fields
`define LFC_STOP     2
`define LFC_PAR_EN   3
`define LFC_EVEN     4
`define LFC_FORCE    5
`define LFC_BREAK    6
// modem_line_control fields
`define MLC_DTR      0
`define MLC_RTS      1
`define MLC_PAIR     2
`define MLC_IMM      3
`define MLC_LOOP     4
`define MLC_XANY     5
`define MLC_IR       6
`define MLC_PRESC    7
// other control fields
`define EFR_SWFLOW   0
`define EFR_ENH      4
`define EFR_AUTO_IN  6
`define EFR_AUTO_OUT 7
`define MIS_RXDIS    2
`define MIS_TXDIS    3
`define IER_LSI      2
// reset values
`define LFC_RST      8'h00
`define MLC_RST      8'h00
`define DIV_RST      16'h0001
// flow characters and timing in oversample ticks
`define XON_CHAR     8'h11
`define XOFF_CHAR    8'h13
`define BIT_LAST     5'h0f
`define STOP15_LAST  5'h17
`define STOP2_LAST   5'h1f
`define MID_LAST     4'h7
`define IR_PULSE_LO  5'h07
`define IR_PULSE_HI  5'h09
`define IR_HOLD      5'h10
`endif

// ==== uart_rx_engine.sv ====
`timescale 1ns/1ps
`include "uart_lmc_regs.svh"
module uart_rx_engine (
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	rx_char_if.engine  rx
);
	uart_lmc_pkg::frame_state_t state_r;
	logic [3:0] tc_r;
	logic [2:0] bit_r;
	logic [7:0] sh_r;
	logic       par_r;
	logic       any_high_r;
	logic       valid_r;
	logic [7:0] data_r;
	logic       perr_r;
	logic       ferr_r;
	logic       brk_r;

	// word aligned to bit 0, last data index and frame-break test
	wire [7:0] aligned  = sh_r >> (3'h3 - {1'b0, rx.wl});
	wire [2:0] last_bit = 3'h4 + {1'b0, rx.wl};
	wire       sample   = rx.tick && tc_r == 4'hf;
	wire       is_brk   = !rx.line && !any_high_r;

	assign rx.valid = valid_r;
	assign rx.data  = data_r;
	assign rx.perr  = perr_r;
	assign rx.ferr  = ferr_r;
	assign rx.brk   = brk_r;

	// frame walker sampling each bit in its middle
	always_ff @(posedge clk_i) begin
		valid_r <= 1'b0;
		if (rst_i) begin
			state_r    <= uart_lmc_pkg::ST_IDLE;
			tc_r       <= 4'h0;
			bit_r      <= 3'h0;
			sh_r       <= 8'h00;
			par_r      <= 1'b0;
			any_high_r <= 1'b0;
			data_r     <= 8'h00;
			perr_r     <= 1'b0;
			ferr_r     <= 1'b0;
			brk_r      <= 1'b0;
		end else if (rx.tick) begin
			tc_r <= tc_r + 4'h1;
			case (state_r)
				uart_lmc_pkg::ST_IDLE: begin
					tc_r <= 4'h0;
					if (rx.enable && !rx.line)
						state_r <= uart_lmc_pkg::ST_START;
				end
				uart_lmc_pkg::ST_START: begin
					if (tc_r == `MID_LAST) begin
						tc_r       <= 4'h0;
						bit_r      <= 3'h0;
						any_high_r <= 1'b0;
						state_r    <= rx.line ? uart_lmc_pkg::ST_IDLE : uart_lmc_pkg::ST_DATA; // R24
					end
				end
				uart_lmc_pkg::ST_DATA: begin
					if (sample) begin
						sh_r       <= {rx.line, sh_r[7:1]}; // R24
						any_high_r <= any_high_r | rx.line;
						bit_r      <= bit_r + 3'h1;
						if (bit_r == last_bit) // R3
							state_r <= rx.par_en ? uart_lmc_pkg::ST_PAR : uart_lmc_pkg::ST_STOP; // R1
					end
				end
				uart_lmc_pkg::ST_PAR: begin
					if (sample) begin
						par_r      <= rx.line;
						any_high_r <= any_high_r | rx.line;
						state_r    <= uart_lmc_pkg::ST_STOP;
					end
				end
				uart_lmc_pkg::ST_STOP: begin
					if (sample) begin
						valid_r <= 1'b1;
						data_r  <= aligned;
						ferr_r  <= !rx.line;
						perr_r  <= rx.par_en && (par_r != uart_lmc_pkg::parity_bit(aligned, rx.wl, rx.even,
							rx.force_en)); // R1 R23
						brk_r   <= is_brk; // R18
						state_r <= is_brk ? uart_lmc_pkg::ST_BRK : uart_lmc_pkg::ST_IDLE;
					end
				end
				uart_lmc_pkg::ST_BRK: begin
					if (rx.line) // R18
						state_r <= uart_lmc_pkg::ST_IDLE;
				end
				default: state_r <= uart_lmc_pkg::ST_IDLE;
			endcase
		end
	end
endmodule
